/* core/restart_pkg.sv */
// Summary of operation
// - After power-up run self test, then show configured response time on display.
// - Once ready, primary status lamp is steady green or red, never flashing.
// - Red lamp lit whole time restart is locked; both safety outputs off then.
// - Yellow lamp lit when field clear and interlock enabled: unlock possible.
// - Button press released between 0.15 s and 4 s moves receiver to ON.
// - Button held 4 s or longer: reset request discarded, interlock stays locked.
// - Button held 30 s: assume short to supply, enter fault interlock state.
// - Field clear and release permitted: lamp steady green, both safety outputs on.
// - Alignment indication enabled: display flashes segments showing beam quality.
// - After field interruption or power loss stay locked until a valid reset.
// - Button terminal drives the button lamp, inverse of safety outputs; with interlock selected it drives only while outputs are on.
package restart_pkg;

    // Timing figures and derived cycle counts
    localparam longint unsigned CLK_HZ        = 100_000_000;
    localparam longint unsigned SELF_TEST_MS  = 20;
    localparam longint unsigned SHOW_RT_MS    = 1000;
    localparam longint unsigned MIN_PRESS_MS  = 150;
    localparam longint unsigned MAX_PRESS_MS  = 4000;
    localparam longint unsigned STUCK_MS      = 30000;
    localparam longint unsigned BLINK_MS      = 250;

    localparam logic [31:0] SELF_TEST_CYC = 32'((SELF_TEST_MS * CLK_HZ) / 1000);
    localparam logic [31:0] SHOW_RT_CYC   = 32'((SHOW_RT_MS * CLK_HZ) / 1000);
    localparam logic [31:0] MIN_PRESS_CYC = 32'((MIN_PRESS_MS * CLK_HZ + 999) / 1000);
    localparam logic [31:0] MAX_PRESS_CYC = 32'((MAX_PRESS_MS * CLK_HZ) / 1000);
    localparam logic [31:0] STUCK_CYC     = 32'((STUCK_MS * CLK_HZ) / 1000);
    localparam logic [31:0] BLINK_CYC     = 32'((BLINK_MS * CLK_HZ) / 1000);

    // Register offsets (byte addresses)
    localparam logic [11:0] REG_CTRL      = 12'h000;
    localparam logic [11:0] REG_RESP_TIME = 12'h004;
    localparam logic [11:0] REG_STATUS    = 12'h008;
    localparam logic [11:0] REG_EVENTS    = 12'h00C;
    localparam logic [11:0] REG_PRESS_LEN = 12'h010;

    // Field positions
    localparam int CTRL_ALIGN_BIT   = 0;
    localparam int CTRL_FCLR_BIT    = 1;
    localparam int STAT_STATE_LSB   = 0;
    localparam int STAT_FIELD_BIT   = 3;
    localparam int STAT_ILK_BIT     = 4;
    localparam int STAT_SAFE_BIT    = 5;
    localparam int STAT_YELLOW_BIT  = 6;
    localparam int STAT_PRESSED_BIT = 7;
    localparam int EVT_SHORT_BIT    = 0;
    localparam int EVT_VALID_BIT    = 1;
    localparam int EVT_IGNORED_BIT  = 2;
    localparam int EVT_STUCK_BIT    = 3;

    // Values after reset and display codes
    localparam logic [7:0]  RESP_TIME_RST = 8'h0E;
    localparam logic [7:0]  DISP_TEST     = 8'hFF;
    localparam logic [7:0]  DISP_BLANK    = 8'h00;
    localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;

    typedef enum logic [2:0] {
        ST_SELFTEST = 3'b000,
        ST_SHOW_RT  = 3'b001,
        ST_LOCKED   = 3'b010,
        ST_ON       = 3'b011,
        ST_FAULT    = 3'b100
    } state_t;

endpackage

/* core/level_sync.sv */
`timescale 1ns/1ps
module level_sync #(
    parameter int W = 1
) (
    input  wire logic         mclk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] level
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] level;
    } sync_t;

    sync_t r;
    sync_t next_r;

    always_comb
    begin
        next_r    = r;
        next_r.s1 = async_in;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        // Accept a change only once stages two and three agree
        next_r.level = (r.s2 & r.s3) | (r.level & (r.s2 ^ r.s3));
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            r <= '0;
        else
            r <= next_r;
    end

    assign level = r.level;
endmodule

/* core/press_timer.sv */
`timescale 1ns/1ps
module press_timer #(
    parameter logic [31:0] MIN_CYC   = 32'h0000_0001,
    parameter logic [31:0] MAX_CYC   = 32'h0000_0002,
    parameter logic [31:0] STUCK_CYC = 32'h0000_0003
) (
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic        pressed,
    output logic             too_short,
    output logic             valid_press,
    output logic             ignored,
    output logic             stuck,
    output logic      [31:0] duration
);
    typedef struct packed {
        logic        prev;
        logic [31:0] cnt;
        logic        stuck_seen;
        logic        too_short;
        logic        valid_press;
        logic        ignored;
        logic        stuck;
        logic [31:0] duration;
    } timer_t;

    timer_t r;
    timer_t next_r;

    localparam logic [31:0] ZERO = 32'h0000_0000;

    always_comb
    begin
        next_r             = r;
        next_r.too_short   = 1'b0;
        next_r.valid_press = 1'b0;
        next_r.ignored     = 1'b0;
        next_r.stuck       = 1'b0;
        next_r.prev        = pressed;
        if (pressed && r.cnt != 32'hFFFF_FFFF)
            next_r.cnt = r.cnt + 32'h0000_0001;
        if (pressed && !r.stuck_seen && r.cnt == STUCK_CYC - 32'h0000_0001)
        begin
            next_r.stuck      = 1'b1;
            next_r.stuck_seen = 1'b1;
        end
        if (r.prev && !pressed)
        begin
            next_r.duration   = r.cnt;
            next_r.cnt        = ZERO;
            next_r.stuck_seen = 1'b0;
            if (r.cnt < MIN_CYC)
                next_r.too_short = 1'b1;
            else if (r.cnt < MAX_CYC)
                next_r.valid_press = 1'b1;
            else
                next_r.ignored = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            r <= '0;
        else
            r <= next_r;
    end

    assign too_short   = r.too_short;
    assign valid_press = r.valid_press;
    assign ignored     = r.ignored;
    assign stuck       = r.stuck;
    assign duration    = r.duration;
endmodule

/* core/restart_interlock_control.sv */
`timescale 1ns/1ps
module restart_interlock_control #(
    parameter logic [31:0] SELF_TEST_CYCLES = restart_pkg::SELF_TEST_CYC,
    parameter logic [31:0] SHOW_RT_CYCLES   = restart_pkg::SHOW_RT_CYC,
    parameter logic [31:0] MIN_PRESS_CYCLES = restart_pkg::MIN_PRESS_CYC,
    parameter logic [31:0] MAX_PRESS_CYCLES = restart_pkg::MAX_PRESS_CYC,
    parameter logic [31:0] STUCK_CYCLES     = restart_pkg::STUCK_CYC,
    parameter logic [31:0] BLINK_CYCLES     = restart_pkg::BLINK_CYC
) (
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        field_clear,
    input  wire logic        release_ok,
    input  wire logic [7:0]  beam_quality,
    input  wire logic        reset_button_terminal_in,
    input  wire logic        interlock_select_input,
    output logic             reset_button_terminal_out,
    output logic             reset_button_terminal_oe_n,
    output logic             safety_output_a,
    output logic             safety_output_b,
    output logic             primary_status_lamp_green,
    output logic             primary_status_lamp_red,
    output logic             unlock_lamp_yellow,
    output logic      [7:0]  display_code
);
    import restart_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////

    typedef struct packed {
        state_t      state;
        logic [31:0] cnt;
        logic [31:0] blink_cnt;
        logic        blink;
        logic        align_en;
        logic        fault_clr;
        logic [7:0]  resp_time;
        logic [3:0]  events;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        term_out;
        logic        term_oe_n;
        logic        pin_free;
        logic        safe;
        logic        green;
        logic        red;
        logic        yellow;
        logic [7:0]  display;
    } ctl_t;

    ctl_t r;
    ctl_t next_r;

    logic [1:0]  pins;
    logic        button_level;
    logic        ilk_sel;
    logic        pressed;
    logic        ev_short;
    logic        ev_valid;
    logic        ev_ignored;
    logic        ev_stuck;
    logic [31:0] press_len;

    ////////////////////////////////////////////////////////////////////////////////

    level_sync #(
        .W (2)
    ) u_sync (
        .mclk     (mclk),
        .rstn     (rstn),
        .async_in ({interlock_select_input, reset_button_terminal_in}),
        .level    (pins)
    );

    assign button_level = pins[0];
    // interlock selected by a high level
    assign ilk_sel = pins[1];
    // Own lamp drive would read back as a press, so only count while released
    assign pressed = button_level & r.pin_free;

    press_timer #(
        .MIN_CYC   (MIN_PRESS_CYCLES),
        .MAX_CYC   (MAX_PRESS_CYCLES),
        .STUCK_CYC (STUCK_CYCLES)
    ) u_timer (
        .mclk        (mclk),
        .rstn        (rstn),
        .pressed     (pressed),
        .too_short   (ev_short),
        .valid_press (ev_valid),
        .ignored     (ev_ignored),
        .stuck       (ev_stuck),
        .duration    (press_len)
    );

    ////////////////////////////////////////////////////////////////////////////////

    function automatic logic addr_hit(input logic [11:0] a);
        addr_hit = (a == REG_CTRL) || (a == REG_RESP_TIME) || (a == REG_STATUS)
                   || (a == REG_EVENTS) || (a == REG_PRESS_LEN);
    endfunction

    function automatic logic [31:0] read_word(input logic [11:0] a, input ctl_t c,
                                              input logic ilk, input logic fc,
                                              input logic prs, input logic [31:0] len);
        logic [31:0] w;
        w = ZERO_WORD;
        unique case (a)
            REG_CTRL:
            begin
                w[CTRL_ALIGN_BIT] = c.align_en;
            end
            REG_RESP_TIME:
            begin
                w[7:0] = c.resp_time;
            end
            REG_STATUS:
            begin
                w[STAT_STATE_LSB +: 3] = c.state;
                w[STAT_FIELD_BIT]      = fc;
                w[STAT_ILK_BIT]        = ilk;
                w[STAT_SAFE_BIT]       = c.safe;
                w[STAT_YELLOW_BIT]     = c.yellow;
                w[STAT_PRESSED_BIT]    = prs;
            end
            REG_EVENTS:
            begin
                w[3:0] = c.events;
            end
            REG_PRESS_LEN:
            begin
                w = len;
            end
            default:
            begin
                w = ZERO_WORD;
            end
        endcase
        read_word = w;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        logic       setup;
        logic       wr;
        logic [3:0] new_ev;
        setup  = psel & ~penable;
        wr     = psel & penable & r.pready & pwrite;
        new_ev = 4'h0;
        next_r = r;

        // Display flash timebase
        if (r.blink_cnt >= BLINK_CYCLES - 32'h0000_0001)
        begin
            next_r.blink_cnt = ZERO_WORD;
            next_r.blink     = ~r.blink;
        end
        else
        begin
            next_r.blink_cnt = r.blink_cnt + 32'h0000_0001;
        end

        // Bus slave: answer ready in the first access cycle
        next_r.pready    = setup;
        next_r.pslverr   = setup & ~addr_hit(paddr);
        next_r.prdata    = setup ? read_word(paddr, r, ilk_sel, field_clear, pressed,
                                             press_len) : ZERO_WORD;
        next_r.fault_clr = 1'b0;
        if (wr && paddr == REG_CTRL)
        begin
            next_r.align_en  = pwdata[CTRL_ALIGN_BIT];
            next_r.fault_clr = pwdata[CTRL_FCLR_BIT];
        end
        if (wr && paddr == REG_RESP_TIME)
            next_r.resp_time = pwdata[7:0];

        // Sticky press history; a new event beats a same-cycle clear
        new_ev[EVT_SHORT_BIT]   = ev_short;
        new_ev[EVT_VALID_BIT]   = ev_valid;
        new_ev[EVT_IGNORED_BIT] = ev_ignored;
        new_ev[EVT_STUCK_BIT]   = ev_stuck;
        if (wr && paddr == REG_EVENTS)
            next_r.events = (r.events & ~pwdata[3:0]) | new_ev;
        else
            next_r.events = r.events | new_ev;

        unique case (r.state)
            ST_SELFTEST:
            begin
                next_r.cnt = r.cnt + 32'h0000_0001;
                if (r.cnt >= SELF_TEST_CYCLES - 32'h0000_0001)
                begin
                    next_r.cnt   = ZERO_WORD;
                    next_r.state = ST_SHOW_RT;
                end
            end
            ST_SHOW_RT:
            begin
                next_r.cnt = r.cnt + 32'h0000_0001;
                if (r.cnt >= SHOW_RT_CYCLES - 32'h0000_0001)
                begin
                    next_r.cnt   = ZERO_WORD;
                    next_r.state = ST_LOCKED;
                end
            end
            ST_LOCKED:
            begin
                if (ev_stuck)
                    next_r.state = ST_FAULT;
                else if (!ilk_sel && field_clear && release_ok)
                    next_r.state = ST_ON;
                else if (ilk_sel && ev_valid && field_clear && release_ok)
                    next_r.state = ST_ON;
            end
            ST_ON:
            begin
                if (ev_stuck)
                    next_r.state = ST_FAULT;
                else if (!field_clear || !release_ok)
                    next_r.state = ST_LOCKED;
            end
            ST_FAULT:
            begin
                // Leave only on software clear with the button released
                if (r.fault_clr && !button_level)
                    next_r.state = ST_LOCKED;
            end
            default:
            begin
                next_r.state = ST_LOCKED;
            end
        endcase

        next_r.safe  = (next_r.state == ST_ON);
        next_r.green = (next_r.state == ST_ON);
        next_r.red   = (next_r.state == ST_LOCKED) || (next_r.state == ST_FAULT);
        next_r.yellow = (next_r.state == ST_LOCKED) && field_clear && ilk_sel;
        // button lamp is inverse of outputs
        next_r.term_out  = ~next_r.safe;
        next_r.term_oe_n = ~(next_r.safe | ~ilk_sel);
        // Synced pin still echoes our lamp drive for a few cycles after release
        next_r.pin_free  = next_r.term_oe_n & (r.pin_free | ~button_level);

        unique case (next_r.state)
            ST_SELFTEST:
            begin
                next_r.display = DISP_TEST;
            end
            ST_SHOW_RT:
            begin
                next_r.display = r.resp_time;
            end
            default:
            begin
                next_r.display = (r.align_en && r.blink) ? beam_quality : DISP_BLANK;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////

    // reset forces start-up path, outputs off
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            r           <= '0;
            r.state     <= ST_SELFTEST;
            r.resp_time <= RESP_TIME_RST;
            r.term_out  <= 1'b1;
            r.term_oe_n <= 1'b1;
            r.display   <= DISP_TEST;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign prdata                     = r.prdata;
    assign pready                     = r.pready;
    assign pslverr                    = r.pslverr;
    assign reset_button_terminal_out  = r.term_out;
    assign reset_button_terminal_oe_n = r.term_oe_n;
    assign safety_output_a            = r.safe;
    assign safety_output_b            = r.safe;
    assign primary_status_lamp_green  = r.green;
    assign primary_status_lamp_red    = r.red;
    assign unlock_lamp_yellow         = r.yellow;
    assign display_code               = r.display;
endmodule

/* verif/restart_interlock_properties.sv */
`timescale 1ns/1ps
module restart_interlock_properties #(
    parameter logic [31:0] MIN_PRESS_CYCLES = 32'h0000_000F,
    parameter logic [31:0] MAX_PRESS_CYCLES = 32'h0000_0190,
    parameter logic [31:0] STUCK_CYCLES     = 32'h0000_0BB8
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic field_clear,
    input wire logic release_ok,
    input wire logic reset_button_terminal_in,
    input wire logic reset_button_terminal_out,
    input wire logic reset_button_terminal_oe_n,
    input wire logic safety_output_a,
    input wire logic safety_output_b,
    input wire logic primary_status_lamp_green,
    input wire logic primary_status_lamp_red,
    input wire logic unlock_lamp_yellow
);
    logic [31:0] held;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////
    // Raw hold length; only counted while the pin is read and device is up
    always_ff @(posedge mclk or negedge rstn)
        if (!rstn)
            held <= 32'h0000_0000;
        else if (reset_button_terminal_in && reset_button_terminal_oe_n
                 && (primary_status_lamp_red || primary_status_lamp_green))
            held <= held + 32'h0000_0001;
        else
            held <= 32'h0000_0000;
    ////////////////////////////////////////////////////////////////
    property p_locked_off;
        primary_status_lamp_red |-> !safety_output_a && !safety_output_b;
    endproperty
    a_locked_off: assert property (p_locked_off)
        else $error("safety outputs on while red lamp lit");
    property p_on_lamps;
        safety_output_a |-> safety_output_b && primary_status_lamp_green
            && !primary_status_lamp_red;
    endproperty
    a_on_lamps: assert property (p_on_lamps)
        else $error("outputs on without matching pair and green lamp");
    property p_lamp_inv;
        reset_button_terminal_out != safety_output_a;
    endproperty
    a_lamp_inv: assert property (p_lamp_inv)
        else $error("button lamp not inverse of outputs");
    property p_yellow;
        unlock_lamp_yellow |-> primary_status_lamp_red && $past(field_clear);
    endproperty
    a_yellow: assert property (p_yellow)
        else $error("yellow lamp without locked state and clear field");
    property p_drop;
        !(field_clear && release_ok) |=> !safety_output_a;
    endproperty
    a_drop: assert property (p_drop)
        else $error("outputs stayed on after field or release drop");
    property p_stuck;
        held == STUCK_CYCLES + 32'h0000_0008 |-> primary_status_lamp_red && !safety_output_a;
    endproperty
    a_stuck: assert property (p_stuck)
        else $error("stuck button did not force fault");
    property p_valid;
        $fell(reset_button_terminal_in) && reset_button_terminal_oe_n && unlock_lamp_yellow
            && field_clear && release_ok && held >= MIN_PRESS_CYCLES + 32'h0000_0002
            && held + 32'h0000_0002 < MAX_PRESS_CYCLES |-> ##[1:8] safety_output_a;
    endproperty
    a_valid: assert property (p_valid)
        else $error("valid press did not switch outputs on");
    property p_short;
        $fell(reset_button_terminal_in) && reset_button_terminal_oe_n && primary_status_lamp_red
            && held + 32'h0000_0002 <= MIN_PRESS_CYCLES |=> !safety_output_a [*8];
    endproperty
    a_short: assert property (p_short)
        else $error("short press unlocked outputs");
    property p_long;
        $fell(reset_button_terminal_in) && reset_button_terminal_oe_n
            && held >= MAX_PRESS_CYCLES + 32'h0000_0002 |=> !safety_output_a [*8];
    endproperty
    a_long: assert property (p_long)
        else $error("long press unlocked outputs");
endmodule

bind restart_interlock_control restart_interlock_properties #(
    .MIN_PRESS_CYCLES(MIN_PRESS_CYCLES), .MAX_PRESS_CYCLES(MAX_PRESS_CYCLES),
    .STUCK_CYCLES(STUCK_CYCLES)
) chk_u (
    .mclk, .rstn, .field_clear, .release_ok, .reset_button_terminal_in,
    .reset_button_terminal_out, .reset_button_terminal_oe_n, .safety_output_a,
    .safety_output_b, .primary_status_lamp_green, .primary_status_lamp_red,
    .unlock_lamp_yellow
);

/* verif/button_relay_model.sv */
`timescale 1ns/1ps
module button_relay_model (
    input  wire logic mclk,
    input  wire logic button,
    input  wire logic bridged,
    input  wire logic term_out,
    input  wire logic term_oe_n,
    input  wire logic out_a,
    input  wire logic out_b,
    output logic      pin_level,
    output logic      select_level,
    output logic      relay_on
);
    // Device lamp drive wins; open contact reads low
    assign pin_level = term_oe_n ? button : term_out;
    assign select_level = bridged ? 1'b0 : 1'b1;
    // relay closes only with both channels on
    always_ff @(posedge mclk)
        relay_on <= out_a & out_b;
endmodule

/* verif/restart_interlock_control_tb.sv */
`timescale 1ns/1ps
module restart_interlock_control_tb;
    import restart_pkg::*;
    logic        mclk = 1'b0;
    logic        rstn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready, pslverr, pin, sel, term_out, term_oe_n, out_a, out_b;
    logic        green, red, yellow, relay_on, er;
    logic        field_clear = 1'b0;
    logic        release_ok = 1'b1;
    logic        button = 1'b0;
    logic        bridged = 1'b0;
    logic [7:0]  beam_quality = 8'hA5;
    logic [7:0]  display_code;
    logic [31:0] rd;
    int          n_errors = 0;
    int          num_checks = 0;
    int          k;
    localparam logic [31:0] MIN_LEN   = 32'h0000_000F;
    localparam logic [31:0] MAX_LEN   = 32'h0000_0190;
    localparam logic [31:0] STUCK_LEN = 32'h0000_0BB8;
    always #5 mclk = ~mclk;
    restart_interlock_control #(
        .SELF_TEST_CYCLES(32'h0000_0014), .SHOW_RT_CYCLES(32'h0000_0014),
        .MIN_PRESS_CYCLES(MIN_LEN), .MAX_PRESS_CYCLES(MAX_LEN),
        .STUCK_CYCLES(STUCK_LEN), .BLINK_CYCLES(32'h0000_0004)
    ) dut_u (
        .mclk, .rstn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
        .pslverr, .field_clear, .release_ok, .beam_quality,
        .reset_button_terminal_in(pin), .interlock_select_input(sel),
        .reset_button_terminal_out(term_out), .reset_button_terminal_oe_n(term_oe_n),
        .safety_output_a(out_a), .safety_output_b(out_b),
        .primary_status_lamp_green(green), .primary_status_lamp_red(red),
        .unlock_lamp_yellow(yellow), .display_code
    );
    button_relay_model partner_u (
        .mclk, .button, .bridged, .term_out, .term_oe_n, .out_a, .out_b,
        .pin_level(pin), .select_level(sel), .relay_on
    );
    ////////////////////////////////////////////////////////////////
    task print_verdict;
        $display("checks=%0d errors=%0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Request held until pready is sampled high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1)
            @(posedge mclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task press(input int n);
        button <= 1'b1;
        repeat (n) @(posedge mclk);
        button <= 1'b0;
        repeat (12) @(posedge mclk);
    endtask
    task off_chk;
        chk({28'h000_0000, out_a, out_b, red, relay_on}, 32'h0000_0002);
    endtask
    task wait_red;
        for (k = 0; k < 80 && red !== 1'b1; k++) @(posedge mclk);
    endtask
    ////////////////////////////////////////////////////////////////
    task t_start;
        @(posedge mclk);
        chk({16'h0000, display_code, 6'h00, out_a, out_b}, 32'h0000_FF00);
        for (k = 0; k < 40 && display_code === DISP_TEST; k++) @(posedge mclk);
        chk({24'h00_0000, display_code}, {24'h00_0000, RESP_TIME_RST});
        wait_red;
        repeat (8)
        begin
            @(posedge mclk);
            chk({29'h0000_0000, green, red, out_a}, 32'h0000_0002);
        end
        apb(1'b1, REG_RESP_TIME, 32'h0000_0033);
        apb(1'b0, REG_RESP_TIME, ZERO_WORD);
        chk(rd, 32'h0000_0033);
        apb(1'b0, 12'h020, ZERO_WORD);
        chk({31'h0000_0000, er}, 32'h0000_0001);
    endtask
    task t_yellow;
        chk({31'h0000_0000, yellow}, ZERO_WORD);
        field_clear <= 1'b1;
        repeat (4) @(posedge mclk);
        chk({31'h0000_0000, yellow}, 32'h0000_0001);
    endtask
    task refused(input int n, input logic [31:0] ev);
        press(n);
        off_chk;
        apb(1'b0, REG_EVENTS, ZERO_WORD);
        chk(rd & 32'h0000_0007, ev);
        apb(1'b1, REG_EVENTS, 32'h0000_000F);
    endtask
    task t_valid;
        press(17);
        chk({24'h00_0000, out_a, out_b, green, red, term_out, term_oe_n, relay_on, pin},
            32'h0000_00E2);
    endtask
    task t_drop;
        field_clear <= 1'b0;
        repeat (4) @(posedge mclk);
        off_chk;
        field_clear <= 1'b1;
        repeat (40) @(posedge mclk);
        off_chk;
        press(17);
        rstn <= 1'b0;
        repeat (4) @(posedge mclk);
        rstn <= 1'b1;
        wait_red;
        repeat (20) @(posedge mclk);
        off_chk;
    endtask
    task t_stuck;
        press(3100);
        off_chk;
        apb(1'b0, REG_STATUS, ZERO_WORD);
        chk(rd & 32'h0000_0007, 32'h0000_0004);
        press(17);
        off_chk;
        apb(1'b1, REG_CTRL, 32'h0000_0002);
        apb(1'b0, REG_STATUS, ZERO_WORD);
        chk(rd & 32'h0000_0007, 32'h0000_0002);
    endtask
    task t_align;
        logic [1:0] seen;
        seen = 2'b00;
        beam_quality <= 8'h3C;
        apb(1'b1, REG_CTRL, 32'h0000_0001);
        repeat (12)
        begin
            @(posedge mclk);
            if (display_code === 8'h3C)
                seen[0] = 1'b1;
            if (display_code === DISP_BLANK)
                seen[1] = 1'b1;
        end
        chk({30'h0000_0000, seen}, 32'h0000_0003);
        apb(1'b1, REG_CTRL, ZERO_WORD);
    endtask
    task t_bypass;
        bridged <= 1'b1;
        for (k = 0; k < 30 && out_a !== 1'b1; k++) @(posedge mclk);
        chk({30'h0000_0000, out_a, term_oe_n}, 32'h0000_0002);
        release_ok <= 1'b0;
        repeat (4) @(posedge mclk);
        off_chk;
        release_ok <= 1'b1;
        for (k = 0; k < 30 && out_a !== 1'b1; k++) @(posedge mclk);
        chk({31'h0000_0000, out_a}, 32'h0000_0001);
        bridged <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (4) @(posedge mclk);
        rstn <= 1'b1;
        t_start;
        t_yellow;
        refused(13, 32'h0000_0001);
        refused(402, 32'h0000_0004);
        t_valid;
        t_drop;
        t_stuck;
        t_align;
        t_bypass;
        print_verdict;
    end
    // Whole run is about 3900 cycles
    initial
    begin
        repeat (12000) @(posedge mclk);
        n_errors++;
        print_verdict;
    end
endmodule
